// ### src/port_defs.vh
// Constants for the eight-bit port with segment takeover
`ifndef PORT_DEFS_VH
`define PORT_DEFS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_PORT_OUTPUT_LATCH 16'hffdb
`define ADDR_PORT_DIRECTION_CONTROL 16'hffeb
`define ADDR_LCD_PORT_CONTROL 16'hffc0
`define ADDR_PORT_STATUS 16'hffc1

// ----------------------------------------
// Reset and read values
// ----------------------------------------
`define RST_PORT_OUTPUT_LATCH 8'h00
`define RST_PORT_DIRECTION_CONTROL 8'h00
`define RST_SEGMENT_SELECT 4'h0
`define RD_WRITE_ONLY 8'hff
`define RD_UNMAPPED 8'h00

// ----------------------------------------
// Segment select field position and ranges
// ----------------------------------------
`define SGSEL_LSB 0
`define SGSEL_MSB 3
`define SEG_UPPER_FIRST 4'h8
`define SEG_UPPER_LAST 4'hf
`define SEG_LOWER_FIRST 4'h7
`define SEG_LOWER_LAST 4'he

// ----------------------------------------
// Operating mode codes
// ----------------------------------------
`define MODE_ACTIVE 3'h0
`define MODE_SUBACTIVE 3'h1
`define MODE_SLEEP 3'h2
`define MODE_SUBSLEEP 3'h3
`define MODE_WATCH 3'h4
`define MODE_STANDBY 3'h5

`endif

// ### src/pin_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Pin level and filtered result
    input wire async_in,
    output reg level_r
);

reg s1_r;
reg s2_r;
reg s3_r;

always @(posedge clk) begin
    if (rst) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
        level_r <= 1'b0;
    end else begin
        s1_r <= async_in;
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) begin
            level_r <= s3_r;
        end
    end
end

endmodule // pin_sync

// ### src/port_pin_cell.v
// One port pin: segment takeover, direction and output drive
`timescale 1ns/1ps
`include "port_defs.vh"
module port_pin_cell #(
    parameter UPPER = 1
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Settings for this pin
    input wire [3:0] seg_sel,
    input wire dir,
    input wire latch,
    input wire seg_in,
    // Pin state control
    input wire run,
    input wire hiz,
    // Pin drive
    output reg pin_out_r,
    output reg pin_oe_n_r,
    output wire seg_mode
);

wire out_nxt;
wire oe_n_nxt;

// ----------------------------------------
// Function select
// ----------------------------------------
assign seg_mode = UPPER ?
    (seg_sel >= `SEG_UPPER_FIRST && seg_sel <= `SEG_UPPER_LAST) :
    (seg_sel >= `SEG_LOWER_FIRST && seg_sel <= `SEG_LOWER_LAST);

// Segment drive ignores direction, else latch when output
assign out_nxt = seg_mode ? seg_in : latch;
assign oe_n_nxt = seg_mode ? 1'b0 : ~dir;

// ----------------------------------------
// Output flops
// ----------------------------------------
always @(posedge clk) begin
    if (rst) begin
        pin_out_r <= 1'b0;
        pin_oe_n_r <= 1'b1;
    end else if (hiz) begin
        pin_out_r <= 1'b0;
        pin_oe_n_r <= 1'b1;
    end else if (run) begin
        pin_out_r <= out_nxt;
        pin_oe_n_r <= oe_n_nxt;
    end
end

endmodule // port_pin_cell

// ### src/gpio_port8.v
// Eight-bit general port with LCD segment takeover
//
// Overview of operation
// - A port read returns the latch bit for every pin whose direction bit is one.
// - A port read returns the sampled pin level for every pin whose direction bit is zero.
// - Reset clears the port output latch to zero.
// - A direction bit of one makes its pin an output, zero an input, one bit per pin.
// - Direction and latch only act on a pin while the segment select field gives it to general use.
// - Reset clears the direction register, so every pin starts as an input.
// - The direction register is write-only and reads back as all ones.
// - Pins 7 to 4 carry segment outputs for select codes 1000 to 1111, ignoring direction.
// - Pins 3 to 0 carry segment outputs for select codes 0111 to 1110, ignoring direction.
// - Pins float in reset and standby, hold in sleep and watch, and run in active and subactive.
`timescale 1ns/1ps
`include "port_defs.vh"
module gpio_port8 #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Register port
    input wire [15:0] addr,
    input wire [7:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    output reg [7:0] rd_data_r,
    // Operating mode from system control
    input wire [2:0] op_mode,
    // Segment data from the LCD driver
    input wire [WIDTH-1:0] lcd_segment_outputs,
    // Port pins
    input wire [WIDTH-1:0] general_io_pins_in,
    output wire [WIDTH-1:0] general_io_pins_out,
    output wire [WIDTH-1:0] general_io_pins_oe_n
);

// ----------------------------------------
// Pin state machine codes
// ----------------------------------------
localparam [1:0] PST_FLOAT = 2'd0;
localparam [1:0] PST_RUN = 2'd1;
localparam [1:0] PST_HOLD = 2'd2;

// ----------------------------------------
// Declarations
// ----------------------------------------
reg [WIDTH-1:0] port_output_latch_r;
reg [WIDTH-1:0] port_output_latch_nxt;
reg [WIDTH-1:0] port_direction_control_r;
reg [WIDTH-1:0] port_direction_control_nxt;
reg [3:0] segment_select_field_r;
reg [3:0] segment_select_field_nxt;
reg [1:0] pin_state_r;
reg [1:0] pin_state_nxt;
reg [7:0] rd_data_nxt;
reg [WIDTH-1:0] port_read_value;
wire [WIDTH-1:0] pin_level;
wire [WIDTH-1:0] seg_mode;
wire sel_latch;
wire sel_dir;
wire sel_lcd_port_control_register;
wire sel_status;
wire run;
wire hiz;

// ----------------------------------------
// Address decode
// ----------------------------------------
assign sel_latch = (addr == `ADDR_PORT_OUTPUT_LATCH);
assign sel_dir = (addr == `ADDR_PORT_DIRECTION_CONTROL);
assign sel_lcd_port_control_register = (addr == `ADDR_LCD_PORT_CONTROL);
assign sel_status = (addr == `ADDR_PORT_STATUS);

// ----------------------------------------
// Register writes
// ----------------------------------------
always @* begin
    port_output_latch_nxt = port_output_latch_r;
    port_direction_control_nxt = port_direction_control_r;
    segment_select_field_nxt = segment_select_field_r;
    if (wr_en) begin
        if (sel_latch) begin
            port_output_latch_nxt = wr_data[WIDTH-1:0];
        end
        if (sel_dir) begin
            port_direction_control_nxt = wr_data[WIDTH-1:0];
        end
        if (sel_lcd_port_control_register) begin
            segment_select_field_nxt = wr_data[`SGSEL_MSB:`SGSEL_LSB];
        end
    end
end

always @(posedge clk) begin
    if (rst) begin
        port_output_latch_r <= `RST_PORT_OUTPUT_LATCH;
        port_direction_control_r <= `RST_PORT_DIRECTION_CONTROL;
        segment_select_field_r <= `RST_SEGMENT_SELECT;
    end else begin
        port_output_latch_r <= port_output_latch_nxt;
        port_direction_control_r <= port_direction_control_nxt;
        segment_select_field_r <= segment_select_field_nxt;
    end
end

// ----------------------------------------
// Pin state from operating mode
// ----------------------------------------
always @* begin
    case (op_mode)
        `MODE_ACTIVE: begin
            pin_state_nxt = PST_RUN;
        end
        `MODE_SUBACTIVE: begin
            pin_state_nxt = PST_RUN;
        end
        `MODE_SLEEP: begin
            pin_state_nxt = PST_HOLD;
        end
        `MODE_SUBSLEEP: begin
            pin_state_nxt = PST_HOLD;
        end
        `MODE_WATCH: begin
            pin_state_nxt = PST_HOLD;
        end
        `MODE_STANDBY: begin
            pin_state_nxt = PST_FLOAT;
        end
        default: begin
            pin_state_nxt = PST_FLOAT;
        end
    endcase
end

always @(posedge clk) begin
    if (rst) begin
        pin_state_r <= PST_FLOAT;
    end else begin
        pin_state_r <= pin_state_nxt;
    end
end

assign run = (pin_state_r == PST_RUN);
assign hiz = (pin_state_r == PST_FLOAT);

// ----------------------------------------
// Per-pin logic
// ----------------------------------------
pin_sync u_sync0 (
    .clk(clk),
    .rst(rst),
    .async_in(general_io_pins_in[0]),
    .level_r(pin_level[0])
);
port_pin_cell #(
    .UPPER(0)
) u_cell0 (
    .clk(clk),
    .rst(rst),
    .seg_sel(segment_select_field_r),
    .dir(port_direction_control_r[0]),
    .latch(port_output_latch_r[0]),
    .seg_in(lcd_segment_outputs[0]),
    .run(run),
    .hiz(hiz),
    .pin_out_r(general_io_pins_out[0]),
    .pin_oe_n_r(general_io_pins_oe_n[0]),
    .seg_mode(seg_mode[0])
);

pin_sync u_sync1 (
    .clk(clk),
    .rst(rst),
    .async_in(general_io_pins_in[1]),
    .level_r(pin_level[1])
);
port_pin_cell #(
    .UPPER(0)
) u_cell1 (
    .clk(clk),
    .rst(rst),
    .seg_sel(segment_select_field_r),
    .dir(port_direction_control_r[1]),
    .latch(port_output_latch_r[1]),
    .seg_in(lcd_segment_outputs[1]),
    .run(run),
    .hiz(hiz),
    .pin_out_r(general_io_pins_out[1]),
    .pin_oe_n_r(general_io_pins_oe_n[1]),
    .seg_mode(seg_mode[1])
);

pin_sync u_sync2 (
    .clk(clk),
    .rst(rst),
    .async_in(general_io_pins_in[2]),
    .level_r(pin_level[2])
);
port_pin_cell #(
    .UPPER(0)
) u_cell2 (
    .clk(clk),
    .rst(rst),
    .seg_sel(segment_select_field_r),
    .dir(port_direction_control_r[2]),
    .latch(port_output_latch_r[2]),
    .seg_in(lcd_segment_outputs[2]),
    .run(run),
    .hiz(hiz),
    .pin_out_r(general_io_pins_out[2]),
    .pin_oe_n_r(general_io_pins_oe_n[2]),
    .seg_mode(seg_mode[2])
);

pin_sync u_sync3 (
    .clk(clk),
    .rst(rst),
    .async_in(general_io_pins_in[3]),
    .level_r(pin_level[3])
);
port_pin_cell #(
    .UPPER(0)
) u_cell3 (
    .clk(clk),
    .rst(rst),
    .seg_sel(segment_select_field_r),
    .dir(port_direction_control_r[3]),
    .latch(port_output_latch_r[3]),
    .seg_in(lcd_segment_outputs[3]),
    .run(run),
    .hiz(hiz),
    .pin_out_r(general_io_pins_out[3]),
    .pin_oe_n_r(general_io_pins_oe_n[3]),
    .seg_mode(seg_mode[3])
);

pin_sync u_sync4 (
    .clk(clk),
    .rst(rst),
    .async_in(general_io_pins_in[4]),
    .level_r(pin_level[4])
);
port_pin_cell #(
    .UPPER(1)
) u_cell4 (
    .clk(clk),
    .rst(rst),
    .seg_sel(segment_select_field_r),
    .dir(port_direction_control_r[4]),
    .latch(port_output_latch_r[4]),
    .seg_in(lcd_segment_outputs[4]),
    .run(run),
    .hiz(hiz),
    .pin_out_r(general_io_pins_out[4]),
    .pin_oe_n_r(general_io_pins_oe_n[4]),
    .seg_mode(seg_mode[4])
);

pin_sync u_sync5 (
    .clk(clk),
    .rst(rst),
    .async_in(general_io_pins_in[5]),
    .level_r(pin_level[5])
);
port_pin_cell #(
    .UPPER(1)
) u_cell5 (
    .clk(clk),
    .rst(rst),
    .seg_sel(segment_select_field_r),
    .dir(port_direction_control_r[5]),
    .latch(port_output_latch_r[5]),
    .seg_in(lcd_segment_outputs[5]),
    .run(run),
    .hiz(hiz),
    .pin_out_r(general_io_pins_out[5]),
    .pin_oe_n_r(general_io_pins_oe_n[5]),
    .seg_mode(seg_mode[5])
);

pin_sync u_sync6 (
    .clk(clk),
    .rst(rst),
    .async_in(general_io_pins_in[6]),
    .level_r(pin_level[6])
);
port_pin_cell #(
    .UPPER(1)
) u_cell6 (
    .clk(clk),
    .rst(rst),
    .seg_sel(segment_select_field_r),
    .dir(port_direction_control_r[6]),
    .latch(port_output_latch_r[6]),
    .seg_in(lcd_segment_outputs[6]),
    .run(run),
    .hiz(hiz),
    .pin_out_r(general_io_pins_out[6]),
    .pin_oe_n_r(general_io_pins_oe_n[6]),
    .seg_mode(seg_mode[6])
);

pin_sync u_sync7 (
    .clk(clk),
    .rst(rst),
    .async_in(general_io_pins_in[7]),
    .level_r(pin_level[7])
);
port_pin_cell #(
    .UPPER(1)
) u_cell7 (
    .clk(clk),
    .rst(rst),
    .seg_sel(segment_select_field_r),
    .dir(port_direction_control_r[7]),
    .latch(port_output_latch_r[7]),
    .seg_in(lcd_segment_outputs[7]),
    .run(run),
    .hiz(hiz),
    .pin_out_r(general_io_pins_out[7]),
    .pin_oe_n_r(general_io_pins_oe_n[7]),
    .seg_mode(seg_mode[7])
);

// ----------------------------------------
// Port read value
// ----------------------------------------
always @* begin
    port_read_value = (port_direction_control_r & port_output_latch_r)
        | (~port_direction_control_r & pin_level);
end

// ----------------------------------------
// Read data
// ----------------------------------------
always @* begin
    rd_data_nxt = 8'h00;
    if (rd_en) begin
        if (sel_latch) begin
            rd_data_nxt = port_read_value;
        end else if (sel_dir) begin
            rd_data_nxt = `RD_WRITE_ONLY;
        end else if (sel_lcd_port_control_register) begin
            rd_data_nxt = {4'h0, segment_select_field_r};
        end else if (sel_status) begin
            rd_data_nxt = {seg_mode[WIDTH-1], seg_mode[0], 4'h0, pin_state_r};
        end else begin
            rd_data_nxt = `RD_UNMAPPED;
        end
    end
end

always @(posedge clk) begin
    if (rst) begin
        rd_data_r <= 8'h00;
    end else begin
        rd_data_r <= rd_data_nxt;
    end
end

endmodule // gpio_port8

// ### testbench/gpio_port8_assertions.sv
// Checker for the eight-bit port
`timescale 1ns/1ps
module gpio_port8_checker #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Register port
    input wire [15:0] addr,
    input wire [7:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    input wire [7:0] rd_data_r,
    // Mode, segments, pins
    input wire [2:0] op_mode,
    input wire [WIDTH-1:0] lcd_segment_outputs,
    input wire [WIDTH-1:0] general_io_pins_in,
    input wire [WIDTH-1:0] general_io_pins_out,
    input wire [WIDTH-1:0] general_io_pins_oe_n
);
    // ----------------------------------------
    // Shadow of settings and assertions
    // ----------------------------------------
    reg [7:0] dir_r;
    reg [7:0] lat_r;
    reg [3:0] sel_r;
    reg [7:0] out_exp_r;
    reg [7:0] oe_exp_r;
    wire up = sel_r >= 4'h8;
    wire lo = (sel_r >= 4'h7) && (sel_r <= 4'he);
    wire [7:0] seg = {{4{up}}, {4{lo}}};
    always @(posedge clk) begin
        if (rst) begin
            dir_r <= 8'h00;
            lat_r <= 8'h00;
            sel_r <= 4'h0;
        end else if (wr_en) begin
            if (addr == 16'hffeb) dir_r <= wr_data;
            if (addr == 16'hffdb) lat_r <= wr_data;
            if (addr == 16'hffc0) sel_r <= wr_data[3:0];
        end
        out_exp_r <= (seg & lcd_segment_outputs[7:0]) | (~seg & lat_r);
        oe_exp_r <= ~(seg | dir_r);
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_dir_reads_ones: assert property (rd_en && addr == 16'hffeb |=> rd_data_r == 8'hff)
        else $error("direction read not all ones");
    a_reset_floats: assert property (disable iff (1'b0) rst |=> general_io_pins_oe_n == 8'hff)
        else $error("pins driven in reset");
    a_standby_floats: assert property ((op_mode == 3'h5) [*3] |-> general_io_pins_oe_n == 8'hff)
        else $error("pins driven in standby");
    a_sleep_holds: assert property ((op_mode == 3'h2) [*4] |->
        $stable(general_io_pins_out) && $stable(general_io_pins_oe_n))
        else $error("pins moved in sleep");
    a_pin_value: assert property ((op_mode == 3'h0) [*3] |->
        general_io_pins_out == out_exp_r)
        else $error("pin value wrong");
    a_pin_enable: assert property ((op_mode == 3'h0) [*3] |->
        general_io_pins_oe_n == oe_exp_r)
        else $error("pin enable wrong");
    a_read_latch: assert property (rd_en && addr == 16'hffdb |=>
        ((rd_data_r ^ $past(lat_r)) & $past(dir_r)) == 8'h00)
        else $error("output pin read not latch");
    a_read_idle: assert property (!rd_en |=> rd_data_r == 8'h00)
        else $error("read data outside read slot");
endmodule // gpio_port8_checker

bind gpio_port8 gpio_port8_checker #(.WIDTH(WIDTH)) chk_u (.clk(clk), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data_r(rd_data_r), .op_mode(op_mode),
    .lcd_segment_outputs(lcd_segment_outputs), .general_io_pins_in(general_io_pins_in),
    .general_io_pins_out(general_io_pins_out), .general_io_pins_oe_n(general_io_pins_oe_n));

// ### testbench/pin_side_model.sv
// Pins and segment driver outside the port
`timescale 1ns/1ps
module pin_side_model (
    // From the port
    input wire [7:0] pin_out,
    input wire [7:0] pin_oe_n,
    // Outside drive
    input wire [7:0] ext,
    input wire [7:0] seg_pat,
    // To the port
    output wire [7:0] pin_in,
    output wire [7:0] seg
);
    // ----------------------------------------
    // Wire level per pin
    // ----------------------------------------
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext);
    assign seg = seg_pat;
endmodule // pin_side_model

// ### testbench/tb_top.sv
// Testbench for the eight-bit port
`timescale 1ns/1ps
module tb_top;
    // ----------------------------------------
    // Signals, tasks and tests
    // ----------------------------------------
    reg clk;
    reg rst;
    reg wr_en;
    reg rd_en;
    reg [15:0] addr;
    reg [7:0] wr_data;
    reg [7:0] d;
    reg [7:0] e;
    reg [2:0] op_mode;
    wire [7:0] rd_data_r;
    wire [7:0] pin_in;
    wire [7:0] pin_out;
    wire [7:0] pin_oe_n;
    wire [7:0] seg;
    integer failures;
    integer checked;
    integer i;
    gpio_port8 dut_u (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data_r(rd_data_r), .op_mode(op_mode), .lcd_segment_outputs(seg), .general_io_pins_in(pin_in),
        .general_io_pins_out(pin_out), .general_io_pins_oe_n(pin_oe_n));
    pin_side_model far_u (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext(8'h3c), .seg_pat(8'h96),
        .pin_in(pin_in), .seg(seg));
    task tick(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wr(input [15:0] a, input [7:0] v);
        @(posedge clk);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task rd(input [15:0] a, output [7:0] v);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 v = rd_data_r;
    endtask
    task mode(input [2:0] m);
        @(posedge clk);
        op_mode <= m;
        tick(3);
    endtask
    task chk(input [7:0] g, input [7:0] x);
        checked = checked + 1;
        if (g !== x) begin
            failures = failures + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task tally_and_finish;
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #200000;
        failures = failures + 1;
        tally_and_finish;
    end
    initial begin
        failures = 0;
        checked = 0;
        rst = 1'b1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 16'h0000;
        wr_data = 8'h00;
        op_mode = 3'h0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        tick(3);
        chk(pin_oe_n, 8'hff);
        rd(16'hffeb, d);
        chk(d, 8'hff);
        wr(16'hffeb, 8'hff);
        rd(16'hffdb, d);
        chk(d, 8'h00);
        wr(16'hffdb, 8'ha5);
        wr(16'hffeb, 8'h0f);
        rd(16'hffeb, d);
        chk(d, 8'hff);
        tick(6);
        rd(16'hffdb, d);
        chk(d, 8'h35);
        chk(pin_oe_n, 8'hf0);
        chk(pin_out & 8'h0f, 8'h05);
        rd(16'h0100, d);
        chk(d, 8'h00);
        for (i = 0; i < 16; i = i + 1) begin
            wr(16'hffc0, i[7:0]);
            tick(2);
            e = {{4{i >= 8}}, {4{i >= 7 && i <= 14}}};
            chk(pin_oe_n, ~(e | 8'h0f));
            chk(pin_out & (e | 8'h0f), (e & 8'h96) | (~e & 8'h05));
            rd(16'hffc0, d);
            chk(d, {4'h0, i[3:0]});
            rd(16'hffc1, d);
            chk(d, {e[7], e[0], 6'h01});
        end
        wr(16'hffc0, 8'h00);
        mode(3'h5);
        chk(pin_oe_n, 8'hff);
        mode(3'h0);
        chk(pin_oe_n, 8'hf0);
        mode(3'h6);
        chk(pin_oe_n, 8'hff);
        mode(3'h0);
        chk(pin_oe_n, 8'hf0);
        for (i = 2; i < 5; i = i + 1) begin
            mode(i[2:0]);
            wr(16'hffeb, i[7:0]);
            tick(3);
            chk(pin_oe_n, 8'hf0);
        end
        mode(3'h1);
        chk(pin_oe_n, 8'hfb);
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        tick(3);
        chk(pin_oe_n, 8'hff);
        wr(16'hffeb, 8'hff);
        rd(16'hffdb, d);
        chk(d, 8'h00);
        tally_and_finish;
    end
endmodule // tb_top
